/* File: bcs_far_model.sv */
/*
  bcs_far_model: line side stand-in with a free running master reference
  clock and recovered channel clock levels set by the bench.
  assumes i_clk is far faster than the reference clock it makes.
*/
`timescale 1ns/10ps
`default_nettype none
module bcs_far_model
#(
  parameter int HALF = 12
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_rec_pat,
  output logic o_master_clk,
  output logic [7:0] o_recovered_rx_clock
);
  int cnt;
  // ==========================================================
  // steady reference clock
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt <= 0;
      o_master_clk <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        o_master_clk <= ~o_master_clk;
    end
    o_recovered_rx_clock <= i_rec_pat;
  end
endmodule
`default_nettype wire

/* File: bcs_pkg.sv */
/*
  bcs_pkg: register map, field layout, reset values and timing counts for
  the receive bit tally, reset and clock select block.
  assumes an 8-bit register port and a 250 MHz core clock.
*/
`default_nettype none
package bcs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_MCLK_FREQ_SELECT = 8'h01;
  localparam logic [7:0] ADDR_CLOCK_OUTPUT_SELECT = 8'h02;
  localparam logic [7:0] ADDR_RX_BIT_COUNT_BYTE0 = 8'h18;
  localparam logic [7:0] ADDR_RX_BIT_COUNT_BYTE1 = 8'h19;
  localparam logic [7:0] ADDR_RX_BIT_COUNT_BYTE2 = 8'h1a;
  localparam logic [7:0] ADDR_RX_BIT_COUNT_BYTE3 = 8'h1b;
  // ==========================================================
  // field positions
  localparam int MCS_MULT_LSB = 0;
  localparam int MCS_MULT_W = 3;
  localparam int MCS_PLL_EN_BIT = 3;
  localparam int COS_CHAN_LSB = 0;
  localparam int COS_CHAN_W = 3;
  localparam int COS_AUX_SRC_BIT = 3;
  localparam int COS_LREF_LSB = 4;
  localparam int COS_LREF_W = 2;
  // line reference source encodings
  localparam logic [1:0] LREF_MASTER = 2'h0;
  localparam logic [1:0] LREF_RECOVERED = 2'h1;
  localparam logic [1:0] LREF_ADAPTED = 2'h2;
  localparam logic [1:0] LREF_AUX = 2'h3;
  // ==========================================================
  // reset values and tally maximum
  localparam logic [31:0] RX_BIT_TALLY_RESET = 32'h0000_0000;
  localparam logic [31:0] RX_BIT_TALLY_MAX = 32'hffff_ffff;
  localparam logic [3:0] MCLK_FREQ_SELECT_RESET = 4'h0;
  localparam logic [5:0] CLOCK_OUTPUT_SELECT_RESET = 6'h00;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SOFT_RESET_MIN_PS = 1000000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W = 9;
endpackage
`default_nettype wire

/* File: bcs_top.sv */
/*
  bcs_top: receive bit tally of the pattern tester, power-up and software
  reset, and selection of the master and recovered clocks onto the clock
  outputs.
  assumes bit strobes and sync status come from logic on i_clk; clock pins
  are sampled at i_clk and must be well below half its rate.
*/
// Overview of operation
// - 32-bit tally counts each received bit
// - tally saturates at all ones
// - tally holds while pattern sync lost
// - sync lost is one when unaligned
// - reset returns every register to default
// - soft reset write gives 1us reset
// - lost-signal channels take master clock on o_recovered_rx_clock only
// - all-ones transmit timed from master clock
// - pll clear passes reference unadapted
// - select register picks aux, line clocks
// - select register picks generator channel
`timescale 1ns/10ps
`default_nettype none
module bcs_top
  import bcs_pkg::*;
#(
  parameter int CH = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_bit_valid,
  input wire logic i_pattern_sync_lost,
  input wire logic [CH-1:0] i_signal_loss,
  input wire logic i_ais_send,
  input wire logic i_master_clk,
  input wire logic [CH-1:0] i_recovered_rx_clock,
  output logic [CH-1:0] o_recovered_rx_clock,
  output logic o_aux_clock_out,
  output logic o_line_ref_clock_out,
  output logic o_clkgen_input,
  output logic o_ref_clock,
  output logic o_ais_clock,
  output logic o_pattern_sync_lost,
  output logic o_soft_reset
);
  import bcs_pkg::*;

  localparam int NS = CH + 1;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] filt;
    logic mclk_prev;
    logic [31:0] rx_bit_tally;
    logic [3:0] mclk_freq_select;
    logic [5:0] clock_output_select;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [7:0] rdata;
    logic [MCS_MULT_W-1:0] div_cnt;
    logic adapted;
    logic [CH-1:0] rx_clk;
    logic aux;
    logic lref;
    logic gen_in;
    logic ref_clk;
    logic ais_clk;
    logic sync_lost;
    logic soft_rst;
  } bcs_state_t;

  bcs_state_t st;
  bcs_state_t next_st;

  // ==========================================================
  // helpers
  function automatic logic pick_chan(input logic [NS-1:0] f, input logic [COS_CHAN_W-1:0] c);
    logic r;
    r = 1'b0;
    for (int k = 0; k < CH; k++)
    begin
      if (c == COS_CHAN_W'(k))
      begin
        r = f[k];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] read_mux(input bcs_state_t s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_MCLK_FREQ_SELECT: r = {4'h0, s.mclk_freq_select};
      ADDR_CLOCK_OUTPUT_SELECT: r = {2'h0, s.clock_output_select};
      ADDR_RX_BIT_COUNT_BYTE0: r = s.rx_bit_tally[7:0];
      ADDR_RX_BIT_COUNT_BYTE1: r = s.rx_bit_tally[15:8];
      ADDR_RX_BIT_COUNT_BYTE2: r = s.rx_bit_tally[23:16];
      ADDR_RX_BIT_COUNT_BYTE3: r = s.rx_bit_tally[31:24];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  logic busy;
  logic [COS_CHAN_W-1:0] sel_chan;
  logic [COS_LREF_W-1:0] sel_lref;
  logic mclk_f;
  logic rec_sel;
  logic mclk_rise;

  assign busy = st.rst_cnt != '0;
  assign sel_chan = st.clock_output_select[COS_CHAN_LSB +: COS_CHAN_W];
  assign sel_lref = st.clock_output_select[COS_LREF_LSB +: COS_LREF_W];
  assign mclk_f = st.filt[CH];
  assign rec_sel = pick_chan(st.filt, sel_chan);
  assign mclk_rise = mclk_f & ~st.mclk_prev;

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.rdata = 8'h00;
    // pins pass three flops; a level counts once stages two and three agree
    next_st.s1 = {i_master_clk, i_recovered_rx_clock};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int k = 0; k < NS; k++)
    begin
      if (st.s2[k] == st.s3[k])
      begin
        next_st.filt[k] = st.s2[k];
      end
    end
    next_st.mclk_prev = mclk_f;
    next_st.sync_lost = i_pattern_sync_lost;
    next_st.soft_rst = busy;

    if (busy)
    begin
      next_st.rst_cnt = st.rst_cnt - RST_CNT_W'(1);
      next_st.rx_bit_tally = RX_BIT_TALLY_RESET;
      next_st.mclk_freq_select = MCLK_FREQ_SELECT_RESET;
      next_st.clock_output_select = CLOCK_OUTPUT_SELECT_RESET;
      next_st.div_cnt = '0;
      next_st.adapted = 1'b0;
    end
    else
    begin
      if (i_rx_bit_valid && !i_pattern_sync_lost && st.rx_bit_tally != RX_BIT_TALLY_MAX)
      begin
        next_st.rx_bit_tally = st.rx_bit_tally + 32'h0000_0001;
      end
      if (i_rd)
      begin
        next_st.rdata = read_mux(st, i_addr);
      end
      if (i_wr)
      begin
        case (i_addr)
          // any write starts the reset pulse
          ADDR_SOFT_RESET: next_st.rst_cnt = RST_CNT_W'(SOFT_RESET_CYCLES);
          ADDR_MCLK_FREQ_SELECT: next_st.mclk_freq_select = i_wdata[3:0];
          ADDR_CLOCK_OUTPUT_SELECT: next_st.clock_output_select = i_wdata[5:0];
          default: next_st.rst_cnt = st.rst_cnt;
        endcase
      end
      // adaptation divides by twice the programmed multiple plus two
      if (mclk_rise)
      begin
        if (st.div_cnt == st.mclk_freq_select[MCS_MULT_LSB +: MCS_MULT_W])
        begin
          next_st.div_cnt = '0;
          next_st.adapted = ~st.adapted;
        end
        else
        begin
          next_st.div_cnt = st.div_cnt + MCS_MULT_W'(1);
        end
      end
    end

    // pll clear passes the reference as it arrives
    next_st.ref_clk = st.mclk_freq_select[MCS_PLL_EN_BIT] ? st.adapted : mclk_f;
    // lost signal falls back to master
    for (int k = 0; k < CH; k++)
    begin
      next_st.rx_clk[k] = i_signal_loss[k] ? mclk_f : st.filt[k];
    end
    next_st.gen_in = rec_sel;
    next_st.aux = st.clock_output_select[COS_AUX_SRC_BIT] ? rec_sel : mclk_f;
    case (sel_lref)
      LREF_MASTER: next_st.lref = mclk_f;
      LREF_RECOVERED: next_st.lref = rec_sel;
      LREF_ADAPTED: next_st.lref = st.ref_clk;
      LREF_AUX: next_st.lref = st.aux;
      default: next_st.lref = mclk_f;
    endcase
    next_st.ais_clk = i_ais_send & mclk_f;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_recovered_rx_clock = st.rx_clk;
  assign o_aux_clock_out = st.aux;
  assign o_line_ref_clock_out = st.lref;
  assign o_clkgen_input = st.gen_in;
  assign o_ref_clock = st.ref_clk;
  assign o_ais_clock = st.ais_clk;
  assign o_pattern_sync_lost = st.sync_lost;
  assign o_soft_reset = st.soft_rst;

  // ==========================================================
  // checks
  a_tally_count_up: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && !(i_wr && i_addr == ADDR_SOFT_RESET) && i_rx_bit_valid && !i_pattern_sync_lost
     && st.rx_bit_tally != RX_BIT_TALLY_MAX)
    |=> st.rx_bit_tally == $past(st.rx_bit_tally) + 32'h0000_0001)
    else $error("bit tally did not advance");

  a_tally_saturates: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && st.rx_bit_tally == RX_BIT_TALLY_MAX) |=> st.rx_bit_tally == RX_BIT_TALLY_MAX)
    else $error("bit tally left its maximum");

  a_tally_holds_oos: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && i_pattern_sync_lost) |=> $stable(st.rx_bit_tally))
    else $error("bit tally moved while sync lost");

  a_sync_flag_tracks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_pattern_sync_lost == $past(i_pattern_sync_lost))
    else $error("sync lost flag wrong");

  a_reset_clears_regs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_soft_reset |-> st.rx_bit_tally == RX_BIT_TALLY_RESET
    && st.clock_output_select == CLOCK_OUTPUT_SELECT_RESET)
    else $error("registers not at default in reset");

  a_soft_reset_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && i_wr && i_addr == ADDR_SOFT_RESET)
    |=> ##1 o_soft_reset ##249 o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset pulse length wrong");

  a_rxclk_on_loss: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_signal_loss[0] |=> o_recovered_rx_clock[0] == $past(mclk_f))
    else $error("lost channel not on master clock");

  a_ais_from_master: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_ais_clock == ($past(i_ais_send) && $past(mclk_f)))
    else $error("all-ones timing not from master");

  a_ref_bypass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !st.mclk_freq_select[MCS_PLL_EN_BIT] |=> o_ref_clock == $past(mclk_f))
    else $error("reference adapted with pll off");

  a_aux_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_aux_clock_out == ($past(st.clock_output_select[COS_AUX_SRC_BIT])
    ? $past(rec_sel) : $past(mclk_f)))
    else $error("aux clock source wrong");

  a_gen_channel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sel_chan == 3'h0) |=> o_clkgen_input == $past(st.filt[0]))
    else $error("generator input channel wrong");

  a_read_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");

  a_read_low_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && i_rd && i_addr == ADDR_RX_BIT_COUNT_BYTE0)
    |=> o_rdata == $past(st.rx_bit_tally[7:0]))
    else $error("tally low byte read wrong");

  a_tally_idle_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && !i_rx_bit_valid) |=> $stable(st.rx_bit_tally))
    else $error("bit tally moved with no bit");

  a_busy_reads_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (busy && i_rd) |=> o_rdata == 8'h00)
    else $error("read answered during soft reset");

  a_busy_drops_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (busy && i_wr) |=> st.clock_output_select == CLOCK_OUTPUT_SELECT_RESET
    && st.mclk_freq_select == MCLK_FREQ_SELECT_RESET)
    else $error("write landed during soft reset");

  a_freq_write_lands: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && i_wr && i_addr == ADDR_MCLK_FREQ_SELECT)
    |=> st.mclk_freq_select == $past(i_wdata[3:0]))
    else $error("frequency select write lost");

  a_adapted_steady: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && !mclk_rise) |=> $stable(st.adapted))
    else $error("adapted reference moved off a master edge");

  a_adapted_toggles: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!busy && mclk_rise && st.div_cnt == st.mclk_freq_select[MCS_MULT_LSB +: MCS_MULT_W])
    |=> st.adapted != $past(st.adapted))
    else $error("adapted reference missed its toggle");

  a_lref_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_line_ref_clock_out == (($past(sel_lref) == LREF_MASTER) ? $past(mclk_f)
    : ($past(sel_lref) == LREF_RECOVERED) ? $past(rec_sel)
    : ($past(sel_lref) == LREF_ADAPTED) ? $past(st.ref_clk) : $past(st.aux)))
    else $error("line reference source wrong");

  // a pin level may move only where stages two and three agreed, so one
  // metastable sample can never reach the clock outputs
  a_sync_agree: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> ((st.filt ^ $past(st.filt)) & $past(st.s2 ^ st.s3)) == '0)
    else $error("synchroniser level moved early");

  // per channel routing; the cast assumes CH fits the channel select field
  for (genvar g = 0; g < CH; g++)
  begin : g_chan_chk
    a_chan_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> o_recovered_rx_clock[g]
      == ($past(i_signal_loss[g]) ? $past(mclk_f) : $past(st.filt[g])))
      else $error("channel clock source wrong");

    a_gen_pick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (sel_chan == COS_CHAN_W'(g)) |=> o_clkgen_input == $past(st.filt[g]))
      else $error("generator channel pick wrong");
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
  tb_top: register, bit tally, soft reset and clock select tests.
  assumes bcs_far_model makes a reference clock with 12-cycle half period.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bcs_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_rx_bit_valid = 1'b0;
  logic i_pattern_sync_lost = 1'b0;
  logic [7:0] i_signal_loss = 8'h00;
  logic i_ais_send = 1'b0;
  logic [7:0] rec_pat = 8'ha5;
  logic mclk;
  logic [7:0] rclk, o_rdata, o_recovered_rx_clock;
  logic o_aux_clock_out, o_line_ref_clock_out, o_clkgen_input;
  logic o_ref_clock, o_ais_clock, o_pattern_sync_lost, o_soft_reset;
  logic [7:0] rd_v;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  int k;
  initial forever #2 i_clk = ~i_clk;
  bcs_far_model far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rec_pat(rec_pat),
    .o_master_clk(mclk), .o_recovered_rx_clock(rclk));
  bcs_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_bit_valid(i_rx_bit_valid),
    .i_pattern_sync_lost(i_pattern_sync_lost), .i_signal_loss(i_signal_loss),
    .i_ais_send(i_ais_send), .i_master_clk(mclk), .i_recovered_rx_clock(rclk),
    .o_recovered_rx_clock(o_recovered_rx_clock), .o_aux_clock_out(o_aux_clock_out),
    .o_line_ref_clock_out(o_line_ref_clock_out), .o_clkgen_input(o_clkgen_input),
    .o_ref_clock(o_ref_clock), .o_ais_clock(o_ais_clock),
    .o_pattern_sync_lost(o_pattern_sync_lost), .o_soft_reset(o_soft_reset));
  // ==========================================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", o_rdata, exp);
  endtask
  task automatic tchk(input logic [31:0] exp);
    for (int b = 0; b < 4; b++)
      rchk(ADDR_RX_BIT_COUNT_BYTE0 + 8'(b), exp[8*b +: 8]);
  endtask
  task automatic bits(input int cnt, input logic lost);
    @(posedge i_clk);
    i_pattern_sync_lost <= lost;
    repeat (cnt)
    begin
      @(posedge i_clk);
      i_rx_bit_valid <= 1'b1;
    end
    @(posedge i_clk);
    i_rx_bit_valid <= 1'b0;
    #1;
    chk("sync_lost", o_pattern_sync_lost, lost);
  endtask
  // ==========================================================
  // clock outputs, sampled while the reference pin is steady
  task automatic clk_checks(input logic [5:0] cos);
    logic sel;
    logic aux;
    logic lref;
    sel = rec_pat[cos[2:0]];
    aux = cos[3] ? sel : mclk;
    // pll is off in these passes, so the adapted source is the master clock
    lref = (cos[5:4] == LREF_RECOVERED) ? sel : ((cos[5:4] == LREF_AUX) ? aux : mclk);
    chk("rclk", o_recovered_rx_clock,
      (i_signal_loss & {8{mclk}}) | (~i_signal_loss & rec_pat));
    chk("clkgen", o_clkgen_input, sel);
    chk("aux", o_aux_clock_out, aux);
    chk("lref", o_line_ref_clock_out, lref);
    chk("ais", o_ais_clock, i_ais_send & mclk);
  endtask
  task automatic two_phase(input logic [5:0] cos);
    int i;
    i = 0;
    while (mclk !== 1'b0 && i < 40)
    begin
      @(posedge i_clk);
      #1;
      i++;
    end
    while (mclk !== 1'b1 && i < 40)
    begin
      @(posedge i_clk);
      #1;
      i++;
    end
    if (i >= 40)
    begin
      mismatches++;
      print_verdict();
    end
    repeat (8) @(posedge i_clk);
    #1;
    clk_checks(cos);
    repeat (12) @(posedge i_clk);
    #1;
    clk_checks(cos);
  endtask
  // edges of o_ref_clock in a window of 16 reference half periods
  task automatic ref_toggles(input int exp);
    int t;
    logic last;
    t = 0;
    repeat (48) @(posedge i_clk);
    #1;
    last = o_ref_clock;
    repeat (192)
    begin
      @(posedge i_clk);
      #1;
      if (o_ref_clock !== last)
        t++;
      last = o_ref_clock;
    end
    chk("ref_toggles", t, exp);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    tchk(32'h0);
    rchk(ADDR_MCLK_FREQ_SELECT, 8'h00);
    rchk(ADDR_CLOCK_OUTPUT_SELECT, 8'h00);
    rchk(ADDR_SOFT_RESET, 8'h00);
    rchk(8'h7f, 8'h00);
    wr(ADDR_RX_BIT_COUNT_BYTE0, 8'hff);
    bits(5, 1'b0);
    tchk(32'h5);
    bits(3, 1'b1);
    tchk(32'h5);
    bits(300, 1'b0);
    tchk(32'h131);
    for (k = 0; k < 8; k++)
    begin
      @(posedge i_clk);
      i_signal_loss <= 8'h01 << k;
      i_ais_send <= k[0];
      rec_pat <= 8'ha5 ^ {8{k[1]}};
      wr(ADDR_CLOCK_OUTPUT_SELECT, {2'h0, 2'(k), k[0], 3'(k)});
      rchk(ADDR_CLOCK_OUTPUT_SELECT, {2'h0, 2'(k), k[0], 3'(k)});
      two_phase({2'(k), k[0], 3'(k)});
    end
    wr(ADDR_MCLK_FREQ_SELECT, 8'h00);
    ref_toggles(16);
    wr(ADDR_MCLK_FREQ_SELECT, 8'h09);
    rchk(ADDR_MCLK_FREQ_SELECT, 8'h09);
    ref_toggles(4);
    wr(ADDR_SOFT_RESET, 8'h5a);
    n = 0;
    repeat (400)
    begin
      @(posedge i_clk);
      #1;
      if (o_soft_reset === 1'b1)
        n++;
    end
    chk("soft_reset_len", n, SOFT_RESET_CYCLES);
    tchk(32'h0);
    rchk(ADDR_MCLK_FREQ_SELECT, 8'h00);
    rchk(ADDR_CLOCK_OUTPUT_SELECT, 8'h00);
    wr(ADDR_CLOCK_OUTPUT_SELECT, 8'h15);
    rchk(ADDR_CLOCK_OUTPUT_SELECT, 8'h15);
    wr(ADDR_MCLK_FREQ_SELECT, 8'h0b);
    bits(2, 1'b0);
    tchk(32'h2);
    // power-up reset again in mid-run
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    tchk(32'h0);
    rchk(ADDR_MCLK_FREQ_SELECT, 8'h00);
    rchk(ADDR_CLOCK_OUTPUT_SELECT, 8'h00);
    // accesses while the soft reset runs are dropped
    wr(ADDR_SOFT_RESET, 8'h00);
    rchk(ADDR_RX_BIT_COUNT_BYTE0, 8'h00);
    wr(ADDR_CLOCK_OUTPUT_SELECT, 8'h2a);
    repeat (260) @(posedge i_clk);
    rchk(ADDR_CLOCK_OUTPUT_SELECT, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
